//--- src/ccp_clock_ctrl.sv
// Purpose: Core clock configuration and derived clock enables
// Assumes: One 125 MHz clock; every derived clock is an enable pulse
// Notes:   Derived rates are scaled so the top core setting runs at CLK
`include "ccp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ccp_clock_ctrl #(
  parameter int RELOCK_CYCLES = `CCP_RELOCK_CYC
) (
  input  wire logic                     CLK,
  input  wire logic                     SRST,
  input  wire logic [`CCP_ADDR_W-1:0]   ADDR,
  input  wire logic [31:0]              WDATA,
  input  wire logic                     WR,
  input  wire logic                     RD,
  output logic      [31:0]              RDATA,
  output ccp_pkg::ccp_clk_en_t          CLK_EN,
  output logic      [`CCP_FREQ_W-1:0]   FREQ_SEL,
  output logic                          RELOCK_BUSY
);
  import ccp_pkg::*;

  localparam int CW = $clog2(RELOCK_CYCLES + 1);
  localparam int NCH = 3;
  localparam int RTC_W = 28;

  // ----------------------------------------------------------------------
  // Frequency table
  // ----------------------------------------------------------------------
  // Core rate in 10 kHz units for the standard oscillator
  function automatic logic [`CCP_RATE_W-1:0] core_rate(
    input logic [`CCP_FREQ_W-1:0] code
  );
    logic [`CCP_RATE_W-1:0] r;
    r = 16'h170C;
    case (code)
      5'h00:   r = 16'h170C;
      5'h01:   r = 16'h1CCA;
      5'h02:   r = 16'h2292;
      5'h03:   r = 16'h2850;
      5'h04:   r = 16'h2E18;
      5'h05:   r = 16'h33D6;
      5'h06:   r = 16'h399E;
      5'h07:   r = 16'h3F5C;
      5'h08:   r = 16'h451A;
      5'h09:   r = 16'h4AE2;
      5'h0A:   r = 16'h50A0;
      default: r = 16'h170C;
    endcase
    return r;
  endfunction : core_rate

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  logic cfg_wr;
  logic sw_wr;

  assign cfg_wr = WR && (ADDR == `CCP_OFF_PLL_CFG);
  assign sw_wr  = WR && (ADDR == `CCP_OFF_SWITCH);

  // ----------------------------------------------------------------------
  // Configuration and switch registers
  // ----------------------------------------------------------------------
  logic [`CCP_FREQ_W-1:0] freq_sel;
  logic [`CCP_FREQ_W-1:0] next_freq_sel;
  logic                   sw_en;
  logic                   next_sw_en;
  logic                   sw_div;
  logic                   next_sw_div;
  logic                   cfg_done;
  logic                   next_cfg_done;

  always_comb begin
    next_freq_sel = freq_sel;
    next_sw_en    = sw_en;
    next_sw_div   = sw_div;
    next_cfg_done = cfg_done;
    if (cfg_wr) begin
      // Unsupported codes are refused; the write still forces a relock
      if (WDATA[`CCP_FREQ_W-1:0] <= `CCP_FREQ_MAX) begin
        next_freq_sel = WDATA[`CCP_FREQ_W-1:0];
      end
      next_cfg_done = 1'b1;
    end
    if (sw_wr) begin
      next_sw_en  = WDATA[`CCP_SW_EN_BIT];
      next_sw_div = WDATA[`CCP_SW_DIV_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      freq_sel <= `CCP_FREQ_RESET;
      sw_en    <= 1'b0;
      sw_div   <= 1'b0;
      cfg_done <= 1'b0;
    end else begin
      freq_sel <= next_freq_sel;
      sw_en    <= next_sw_en;
      sw_div   <= next_sw_div;
      cfg_done <= next_cfg_done;
    end
  end

  // ----------------------------------------------------------------------
  // Relock sequencer
  // ----------------------------------------------------------------------
  ccp_state_t    state;
  ccp_state_t    next_state;
  logic [CW-1:0] relock_cnt;
  logic [CW-1:0] next_relock_cnt;

  always_comb begin
    next_state      = state;
    next_relock_cnt = relock_cnt;
    case (state)
      CCP_RUN: begin
        if (cfg_wr) begin
          next_state      = CCP_RELOCK;
          next_relock_cnt = CW'(RELOCK_CYCLES - 1);
        end
      end
      CCP_RELOCK: begin
        if (cfg_wr) begin
          // A further write restarts the full lock interval
          next_relock_cnt = CW'(RELOCK_CYCLES - 1);
        end else if (relock_cnt == '0) begin
          next_state = CCP_RUN;
        end else begin
          next_relock_cnt = relock_cnt - 1'b1;
        end
      end
      default: begin
        next_state      = CCP_RUN;
        next_relock_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state      <= CCP_RUN;
      relock_cnt <= '0;
    end else begin
      state      <= next_state;
      relock_cnt <= next_relock_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // PLL-derived rate generators
  // ----------------------------------------------------------------------
  // Channel 0 core, 1 serial 7.36 MHz, 2 USB/IR/codec 48 MHz.
  // All three stop and restart from phase zero on a relock, as the
  // PLLs themselves would, so the first edges after relock line up.
  logic                   pll_run;
  logic [NCH-1:0]         ch_pulse;
  logic [NCH-1:0]         ch_next;
  logic [`CCP_RATE_W-1:0] ch_inc [NCH];

  assign pll_run   = (state == CCP_RUN) && !cfg_wr;
  assign ch_inc[0] = core_rate(freq_sel);
  assign ch_inc[1] = `CCP_RATE_SERIAL;
  assign ch_inc[2] = `CCP_RATE_USB;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [`CCP_RATE_W-1:0] acc;
      logic [`CCP_RATE_W-1:0] next_acc;
      logic [`CCP_RATE_W:0]   sum;

      always_comb begin
        sum        = {1'b0, acc} + {1'b0, ch_inc[g]};
        next_acc   = '0;
        ch_next[g] = 1'b0;
        if (pll_run) begin
          if (sum >= {1'b0, `CCP_RATE_FULL}) begin
            next_acc   = `CCP_RATE_W'(sum - {1'b0, `CCP_RATE_FULL});
            ch_next[g] = 1'b1;
          end else begin
            next_acc = sum[`CCP_RATE_W-1:0];
          end
        end
      end

      always_ff @(posedge CLK) begin
        if (SRST) begin
          acc         <= '0;
          ch_pulse[g] <= 1'b0;
        end else begin
          acc         <= next_acc;
          ch_pulse[g] <= ch_next[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Half-rate and processor enables
  // ----------------------------------------------------------------------
  logic half_phase;
  logic next_half_phase;
  logic half_pulse;
  logic next_half_pulse;
  logic cpu_pulse;
  logic next_cpu_pulse;

  // Built from the core's next value, not its register, so the half and
  // processor pulses land in the same cycle as the core pulse they follow
  always_comb begin
    next_half_phase = half_phase;
    next_half_pulse = 1'b0;
    if (!pll_run) begin
      next_half_phase = 1'b0;
    end else if (ch_next[0]) begin
      // Every second core edge drives the bus-side units
      next_half_phase = !half_phase;
      next_half_pulse = half_phase;
    end
    // Switching is only honoured once the config has been written
    if (sw_en && sw_div && cfg_done) begin
      next_cpu_pulse = next_half_pulse;
    end else begin
      next_cpu_pulse = ch_next[0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      half_phase <= 1'b0;
      half_pulse <= 1'b0;
      cpu_pulse  <= 1'b0;
    end else begin
      half_phase <= next_half_phase;
      half_pulse <= next_half_pulse;
      cpu_pulse  <= next_cpu_pulse;
    end
  end

  // ----------------------------------------------------------------------
  // Low-frequency domain
  // ----------------------------------------------------------------------
  // Never touched by the relock: timekeeping must not lose ticks
  logic [RTC_W-1:0] rtc_acc;
  logic [RTC_W-1:0] next_rtc_acc;
  logic [RTC_W-1:0] rtc_sum;
  logic             rtc_pulse;
  logic             next_rtc_pulse;

  always_comb begin
    rtc_sum        = rtc_acc + RTC_W'(`CCP_RTC_HZ);
    next_rtc_pulse = 1'b0;
    next_rtc_acc   = rtc_sum;
    if (rtc_sum >= RTC_W'(`CCP_CLK_HZ)) begin
      next_rtc_acc   = rtc_sum - RTC_W'(`CCP_CLK_HZ);
      next_rtc_pulse = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rtc_acc   <= '0;
      rtc_pulse <= 1'b0;
    end else begin
      rtc_acc   <= next_rtc_acc;
      rtc_pulse <= next_rtc_pulse;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (RD) begin
      case (ADDR)
        `CCP_OFF_PLL_CFG: begin
          next_rdata[`CCP_FREQ_W-1:0] = freq_sel;
        end
        `CCP_OFF_SWITCH: begin
          next_rdata[`CCP_SW_EN_BIT]  = sw_en;
          next_rdata[`CCP_SW_DIV_BIT] = sw_div;
        end
        `CCP_OFF_STATUS: begin
          next_rdata[`CCP_ST_BUSY_BIT] = (state == CCP_RELOCK);
          next_rdata[`CCP_ST_CFGD_BIT] = cfg_done;
          next_rdata[`CCP_ST_FREQ_LSB +: `CCP_FREQ_W] = freq_sel;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA         = rdata;
  assign FREQ_SEL      = freq_sel;
  assign RELOCK_BUSY   = (state == CCP_RELOCK);
  // One assignment keeps the struct output a single-driver variable
  assign CLK_EN = '{
    core:   ch_pulse[0],
    cpu:    cpu_pulse,
    half:   half_pulse,
    serial: ch_pulse[1],
    usb:    ch_pulse[2],
    rtc:    rtc_pulse
  };

endmodule : ccp_clock_ctrl

`default_nettype wire

//--- common/ccp_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz system clock
// Notes:   Definitions only
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CCP_ADDR_W          8
`define CCP_OFF_PLL_CFG     8'h00
`define CCP_OFF_SWITCH      8'h04
`define CCP_OFF_STATUS      8'h08

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CCP_FREQ_W          5
`define CCP_FREQ_RESET      5'h00
`define CCP_FREQ_MAX        5'h0A
`define CCP_SW_EN_BIT       0
`define CCP_SW_DIV_BIT      1
`define CCP_ST_BUSY_BIT     0
`define CCP_ST_CFGD_BIT     1
`define CCP_ST_FREQ_LSB     8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CCP_CLK_PERIOD_NS   8
`define CCP_CLK_HZ          125000000
`define CCP_RELOCK_NS       150000
`define CCP_RELOCK_CYC      ((`CCP_RELOCK_NS + `CCP_CLK_PERIOD_NS - 1) / `CCP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Rates in 10 kHz units, scaled to the top core frequency; the RTC rate is in Hz against CCP_CLK_HZ
// ----------------------------------------------------------------------
`define CCP_RATE_W          16
`define CCP_RATE_FULL       16'h50A0
`define CCP_RATE_SERIAL     16'h02E0
`define CCP_RATE_USB        16'h12C0
`define CCP_RTC_HZ          32768

`endif

//--- common/ccp_pkg.sv
// Purpose: Types shared by the clock configuration block
// Assumes: ccp_defs.svh supplies the numbers
// Notes:   Types only
`default_nettype none

package ccp_pkg;

  typedef enum logic [0:0] {
    CCP_RUN    = 1'b0,
    CCP_RELOCK = 1'b1
  } ccp_state_t;

  // One-cycle enables standing in for each derived clock
  typedef struct packed {
    logic core;
    logic cpu;
    logic half;
    logic serial;
    logic usb;
    logic rtc;
  } ccp_clk_en_t;

endpackage : ccp_pkg

`default_nettype wire

//--- dv/ccp_clock_chk.sv
// Purpose: Port-level assertions for the clock configuration block
// Assumes: Bound to ccp_clock_ctrl, same relock count
// Notes:   Rates beyond simple relations are left to the bench
`include "ccp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ccp_clock_chk #(
  parameter int RELOCK_CYCLES = `CCP_RELOCK_CYC
) (
  input wire logic                   CLK,
  input wire logic                   SRST,
  input wire logic [`CCP_ADDR_W-1:0] ADDR,
  input wire logic [31:0]            WDATA,
  input wire logic                   WR,
  input wire logic                   RD,
  input wire logic [31:0]            RDATA,
  input wire ccp_pkg::ccp_clk_en_t   CLK_EN,
  input wire logic [`CCP_FREQ_W-1:0] FREQ_SEL,
  input wire logic                   RELOCK_BUSY
);
  import ccp_pkg::*;
  localparam logic [15:0] RELOCK_LIM = 16'(RELOCK_CYCLES);
  logic [15:0] since_wr;
  logic [15:0] next_since_wr;
  logic [12:0] since_rtc;
  logic [12:0] next_since_rtc;
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  // Saturates so an idle block never looks busy
  always_comb begin
    next_since_wr = (since_wr == 16'hFFFF) ? since_wr : since_wr + 16'h1;
    next_since_rtc = CLK_EN.rtc ? 13'h0 : since_rtc + 13'h1;
    if (WR && ADDR == `CCP_OFF_PLL_CFG) begin
      next_since_wr = 16'h1;
    end
    if (SRST) begin
      next_since_wr = 16'hFFFF;
      next_since_rtc = 13'h0;
    end
  end
  always_ff @(posedge CLK) begin
    since_wr <= next_since_wr;
    since_rtc <= next_since_rtc;
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence cfg_write_s;
    WR && ADDR == `CCP_OFF_PLL_CFG;
  endsequence
  sequence top_settled_s;
    (FREQ_SEL == `CCP_FREQ_MAX && !RELOCK_BUSY) [*4];
  endsequence
  chk_reset_clears_sel:
    assert property ($fell(SRST) |-> FREQ_SEL == 5'h00 && !RELOCK_BUSY)
    else $error("select or busy not cleared by reset");
  chk_freq_write_taken:
    assert property (cfg_write_s ##0 WDATA[4:0] <= `CCP_FREQ_MAX
      |=> FREQ_SEL == $past(WDATA[4:0]))
    else $error("supported code not taken");
  chk_bad_code_kept:
    assert property (cfg_write_s ##0 WDATA[4:0] > `CCP_FREQ_MAX
      |=> $stable(FREQ_SEL))
    else $error("unsupported code changed select");
  chk_relock_busy_len:
    assert property (RELOCK_BUSY == (since_wr <= RELOCK_LIM))
    else $error("relock busy length wrong");
  chk_gates_shut:
    assert property (RELOCK_BUSY || $fell(RELOCK_BUSY)
      |-> CLK_EN[5:1] == 5'h00)
    else $error("derived enable during relock");
  chk_rtc_keeps_running:
    assert property (since_rtc < 13'h0EEC)
    else $error("rtc pulse gap too long");
  chk_top_every_cycle:
    assert property (top_settled_s |-> CLK_EN.core)
    else $error("top code missed a core pulse");
  chk_half_on_core:
    assert property (CLK_EN.half |-> CLK_EN.core)
    else $error("half pulse without core pulse");
  chk_cpu_on_core:
    assert property (CLK_EN.cpu |-> CLK_EN.core)
    else $error("cpu pulse without core pulse");
  chk_rdata_idle_zero:
    assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside read cycle");
endmodule : ccp_clock_chk

bind ccp_clock_ctrl ccp_clock_chk #(.RELOCK_CYCLES(RELOCK_CYCLES)) i_chk (
  .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CLK_EN(CLK_EN), .FREQ_SEL(FREQ_SEL),
  .RELOCK_BUSY(RELOCK_BUSY)
);
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench for the clock configuration block
// Assumes: Relock count shortened to 20 cycles
// Notes:   Pulse rates are counted over 2064-cycle windows; the last cpu/core check uses a 400-cycle window
`include "ccp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ccp_pkg::*;
  localparam int RC = 20;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic [`CCP_ADDR_W-1:0] addr = 8'h00;
  logic [31:0]            wdata = 32'h0;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [31:0]            rdata;
  ccp_clk_en_t            clk_en;
  logic [`CCP_FREQ_W-1:0] freq_sel;
  logic                   relock_busy;
  logic [31:0]            v;
  int                     n;
  int                     c [6];
  int                     mismatches = 0;
  int                     checks_done = 0;

  ccp_clock_ctrl #(.RELOCK_CYCLES(RC)) i_dut (
    .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CLK_EN(clk_en), .FREQ_SEL(freq_sel),
    .RELOCK_BUSY(relock_busy)
  );

  always #4 clk = ~clk;
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic check_rng(input string nm, input int k, input int lo,
                           input int hi);
    checks_done++;
    if (c[k] < lo || c[k] > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, c[k]);
    end
  endtask : check_rng
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  // Call straight after the write so the first busy cycle is seen
  task automatic relock_len(output int m);
    m = 0;
    #1;
    while (relock_busy === 1'b1 && m < 1000) begin
      m++;
      @(posedge clk);
      #1;
    end
  endtask : relock_len
  task automatic count(input int len);
    c = '{default: 0};
    repeat (len) begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 6; k++) c[k] += int'(clk_en[k]);
    end
  endtask : count
  task automatic give_verdict();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    reg_rd(`CCP_OFF_PLL_CFG, v);
    check("pll cfg reset", 32'h0, v);
    reg_rd(`CCP_OFF_STATUS, v);
    check("status reset", 32'h0, v);
    count(2064);
    check_rng("core at code 0", 5, 589, 591);
    check_rng("half at code 0", 3, 294, 296);
    check_rng("cpu at code 0", 4, 589, 591);
    check_rng("serial clock", 2, 73, 74);
    check_rng("usb clock", 1, 479, 481);
    reg_wr(`CCP_OFF_PLL_CFG, 32'h3);
    reg_rd(`CCP_OFF_STATUS, v);
    check("status in relock", 32'h0303, v);
    reg_wr(`CCP_OFF_PLL_CFG, 32'hA);
    relock_len(n);
    check("relock after rewrite", RC, n);
    check("top select", 32'hA, freq_sel);
    reg_rd(`CCP_OFF_STATUS, v);
    check("status settled", 32'h0A02, v);
    count(2064);
    check_rng("core at top code", 5, 2064, 2064);
    check_rng("half at top code", 3, 1032, 1032);
    check_rng("serial at top", 2, 73, 74);
    reg_wr(`CCP_OFF_PLL_CFG, 32'hB);
    relock_len(n);
    check("relock on bad code", RC, n);
    check("bad code kept", 32'hA, freq_sel);
    reg_wr(`CCP_OFF_SWITCH, 32'h3);
    reg_rd(`CCP_OFF_SWITCH, v);
    check("switch readback", 32'h3, v);
    count(2064);
    check_rng("cpu divided", 4, 1032, 1032);
    reg_wr(8'h0C, 32'hFFFFFFFF);
    #1;
    check("unmapped no relock", 32'h0, relock_busy);
    reg_rd(8'h0C, v);
    check("unmapped read", 32'h0, v);
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    reg_rd(`CCP_OFF_SWITCH, v);
    check("switch after reset", 32'h0, v);
    check("select after reset", 32'h0, freq_sel);
    reg_wr(`CCP_OFF_SWITCH, 32'h3);
    count(400);
    check("cpu undivided unconfigured", c[5], c[4]);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
